//--- hw/dcm_defines.svh
// Command codes, field positions, masks and monitor codes for the control block.
`ifndef DCM_DEFINES_SVH
`define DCM_DEFINES_SVH

// Register-select and command address codes.
`define DCM_REGSEL_SFR     2'h0
`define DCM_CMD_CTRL_WR    4'hC
`define DCM_CMD_CTRL_RD    4'hC
`define DCM_CMD_MON_SEL    4'hA
`define DCM_CMD_PWR_DOWN   4'h8
`define DCM_CMD_PWR_UP     4'h9
`define DCM_CMD_SOFT_RST   4'hF

// Wide (14-bit) configuration word fields.
`define DCM_W_PD_STATE     13
`define DCM_W_REF_LEVEL    12
`define DCM_W_BOOST        11
`define DCM_W_REF_SRC      10
`define DCM_W_MON_EN       9
`define DCM_W_THERM_EN     8
`define DCM_W_TGL_HI       3
`define DCM_W_TGL_LO       2
`define DCM_W_MASK         14'h3F0C
`define DCM_W_MON_LSB      8

// Narrow (12-bit) configuration word fields.
`define DCM_N_PD_STATE     11
`define DCM_N_REF_LEVEL    10
`define DCM_N_BOOST        9
`define DCM_N_REF_SRC      8
`define DCM_N_MON_EN       7
`define DCM_N_THERM_EN     6
`define DCM_N_TGL_HI       1
`define DCM_N_TGL_LO       0
`define DCM_N_MASK         12'hFC3
`define DCM_N_MON_LSB      6

// Monitor codes.
`define DCM_MON_EXT_A      6'h24
`define DCM_MON_EXT_B      6'h25
`define DCM_MON_OFF        6'h3F
`define DCM_MON_LAST_CH    6'h0F

`endif

//--- hw/dcm_pkg.sv
// Types shared by the control and monitor-select block.
package dcm_pkg;

    typedef enum logic [1:0] {
        DCM_ROUTE_OFF,
        DCM_ROUTE_CHANNEL,
        DCM_ROUTE_EXT_A,
        DCM_ROUTE_EXT_B
    } dcm_route_t;

    typedef enum logic [1:0] {
        DCM_PWR_ON,
        DCM_PWR_SOFT_DOWN,
        DCM_PWR_THERMAL_DOWN
    } dcm_pwr_t;

endpackage : dcm_pkg

//--- hw/dcm_cfg_if.sv
// Decoded configuration fields passed from the main block to its helpers.
`timescale 1ns/1ns
interface dcm_cfg_if;
    logic       mon_enable;
    logic [5:0] mon_code;
    logic       tgl_hi_en;
    logic       tgl_lo_en;

    modport src (output mon_enable, output mon_code,
                 output tgl_hi_en, output tgl_lo_en);
    modport dst (input mon_enable, input mon_code,
                 input tgl_hi_en, input tgl_lo_en);
endinterface : dcm_cfg_if

//--- hw/dcm_mon_route.sv
// Monitor multiplexer selection decode.
`timescale 1ns/1ns
`include "dcm_defines.svh"
module dcm_mon_route #(
    parameter int NUM_CH = 16
) (
    // Clock and reset.
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // Configuration.
    dcm_cfg_if.dst                  cfg,
    // Routing result.
    output dcm_pkg::dcm_route_t     route_o,
    output logic [3:0]              route_ch_o
);
    dcm_pkg::dcm_route_t route_d;
    dcm_pkg::dcm_route_t route_q;
    logic [3:0]          ch_d;
    logic [3:0]          ch_q;

    // Undefined codes and channels beyond the fitted count stay three-stated.
    always_comb begin
        route_d = dcm_pkg::DCM_ROUTE_OFF;
        ch_d    = 4'h0;
        if (cfg.mon_enable) begin
            if (cfg.mon_code <= `DCM_MON_LAST_CH &&
                    int'(cfg.mon_code) < NUM_CH) begin
                route_d = dcm_pkg::DCM_ROUTE_CHANNEL;
                ch_d    = cfg.mon_code[3:0];
            end else if (cfg.mon_code == `DCM_MON_EXT_A) begin
                route_d = dcm_pkg::DCM_ROUTE_EXT_A;
            end else if (cfg.mon_code == `DCM_MON_EXT_B) begin
                route_d = dcm_pkg::DCM_ROUTE_EXT_B;
            end else begin
                route_d = dcm_pkg::DCM_ROUTE_OFF;
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            route_q <= dcm_pkg::DCM_ROUTE_OFF;
            ch_q    <= 4'h0;
        end else begin
            route_q <= route_d;
            ch_q    <= ch_d;
        end
    end

    assign route_o    = route_q;
    assign route_ch_o = ch_q;
endmodule : dcm_mon_route

//--- hw/dcm_toggle.sv
// Per-channel A/B toggle state driven by the load strobe.
`timescale 1ns/1ns
module dcm_toggle #(
    parameter int NUM_CH = 16
) (
    // Clock and reset.
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // Configuration and strobe.
    dcm_cfg_if.dst                  cfg,
    input  wire logic               load_dac_strobe_i,
    // Per-channel register select, 1 means the B register.
    output logic [NUM_CH-1:0]       sel_b_o
);
    logic [NUM_CH-1:0] sel_d;
    logic [NUM_CH-1:0] sel_q;

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g++) begin : g_ch
            logic grp_en;
            assign grp_en = (g < 8) ? cfg.tgl_lo_en : cfg.tgl_hi_en;
            // A disabled group falls back to its A register.
            always_comb begin
                sel_d[g] = 1'b0;
                if (grp_en) begin
                    sel_d[g] = load_dac_strobe_i ? ~sel_q[g]
                                                 : sel_q[g];
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            sel_q <= '0;
        end else begin
            sel_q <= sel_d;
        end
    end

    assign sel_b_o = sel_q;
endmodule : dcm_toggle

//--- hw/dcm_ctrl.sv
// Configuration word, monitor select and power control of the converter.
//
// Behaviour
// - Narrow monitor code in payload bits 11..6.
// - Command 1100 loads the configuration word.
// - Wide word 14 bits; bits 7..4,1..0 ignored.
// - Bit 13: power-down high-Z or 100k load.
// - Bit 12: internal reference 2.5 V or 1.25 V.
// - Bit 11 turns amplifier boost on.
// - Bit 10 selects internal reference source.
// - Bit 9 enables monitor, else three-state.
// - Bit 8 enables thermal shutdown above 130C.
// - Soft power-up only when die is cool; the code blocks it only while hot after a thermal shutdown.
// - Bits 3,2 enable upper and lower toggle.
// - Eight-channel part ignores bit 3.
// - Load strobe swaps A and B codes.
// - Narrow word 12 bits, same command.
// - Narrow layout shifted down by two bits.
// - Code 63 three-states; wide code bits 13..8.
`timescale 1ns/1ns
`include "dcm_defines.svh"
module dcm_ctrl #(
    parameter int   NUM_CH       = 16,
    parameter bit   NARROW       = 1'b0,
    parameter bit   REF_LEVEL_RST = 1'b1
) (
    // Clock and reset.
    input  wire logic               ref_clk_i,
    input  wire logic               resetn_i,
    // Decoded command word from the serial front end.
    input  wire logic               cmd_valid_i,
    input  wire logic               cmd_read_i,
    input  wire logic               reg_select_hi_i,
    input  wire logic               reg_select_lo_i,
    input  wire logic [3:0]         cmd_addr_i,
    input  wire logic [13:0]        payload_i,
    // Pins and sensors.
    input  wire logic               load_dac_strobe_i,
    input  wire logic               over_temp_i,
    input  wire logic               hw_power_down_i,
    // Readback.
    output logic [13:0]             readback_o,
    output logic                    readback_valid_o,
    // Analog control.
    output logic                    pd_output_state_o,
    output logic                    int_ref_level_o,
    output logic                    amp_boost_o,
    output logic                    ref_source_sel_o,
    output logic                    amps_powered_o,
    // Monitor routing.
    output dcm_pkg::dcm_route_t     monitor_route_o,
    output logic [3:0]              monitor_channel_o,
    // Toggle state.
    output logic [NUM_CH-1:0]       toggle_sel_b_o
);
    logic [13:0]        cfg_d;
    logic [13:0]        cfg_q;
    logic [5:0]         mon_d;
    logic [5:0]         mon_q;
    logic [13:0]        rb_d;
    logic [13:0]        rb_q;
    logic               rbv_d;
    logic               rbv_q;
    dcm_pkg::dcm_pwr_t  pwr_d;
    dcm_pkg::dcm_pwr_t  pwr_q;
    logic               ot_meta_q;
    logic               ot_q;
    logic               hpd_meta_q;
    logic               hpd_q;
    logic               is_sfr;
    logic [13:0]        rst_word;

    dcm_cfg_if cfg_bus ();

    // Picks one configuration field from either layout.
    function automatic logic fld(input logic [13:0] w,
                                 input int wide_pos, input int narrow_pos);
        fld = NARROW ? w[narrow_pos] : w[wide_pos];
    endfunction : fld

    // The reference-level default depends on the supply grade, set by the REF_LEVEL_RST parameter.
    always_comb begin
        rst_word = 14'h0000;
        if (NARROW) begin
            rst_word[`DCM_N_PD_STATE]  = 1'b1;
            rst_word[`DCM_N_REF_LEVEL] = REF_LEVEL_RST;
        end else begin
            rst_word[`DCM_W_PD_STATE]  = 1'b1;
            rst_word[`DCM_W_REF_LEVEL] = REF_LEVEL_RST;
        end
    end

    // Sensor and pin levels come from outside this clock.
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ot_meta_q  <= 1'b0;
            ot_q       <= 1'b0;
            hpd_meta_q <= 1'b0;
            hpd_q      <= 1'b0;
        end else begin
            ot_meta_q  <= over_temp_i;
            ot_q       <= ot_meta_q;
            hpd_meta_q <= hw_power_down_i;
            hpd_q      <= hpd_meta_q;
        end
    end

    assign is_sfr = cmd_valid_i && !reg_select_hi_i && !reg_select_lo_i;

    always_comb begin
        cfg_d = cfg_q;
        mon_d = mon_q;
        pwr_d = pwr_q;
        rb_d  = rb_q;
        rbv_d = 1'b0;
        if (is_sfr) begin
            case (cmd_addr_i)
                `DCM_CMD_CTRL_WR: begin
                    if (cmd_read_i) begin
                        rb_d  = cfg_q;
                        rbv_d = 1'b1;
                    end else if (NARROW) begin
                        cfg_d = {2'b00, payload_i[11:0]
                                 & `DCM_N_MASK};
                    end else begin
                        cfg_d = payload_i & `DCM_W_MASK;
                    end
                end
                `DCM_CMD_MON_SEL: begin
                    if (!cmd_read_i) begin
                        mon_d = NARROW
                            ? payload_i[`DCM_N_MON_LSB +: 6]
                            : payload_i[`DCM_W_MON_LSB +: 6];
                    end
                end
                `DCM_CMD_PWR_DOWN: begin
                    if (!cmd_read_i) begin
                        pwr_d = dcm_pkg::DCM_PWR_SOFT_DOWN;
                    end
                end
                `DCM_CMD_PWR_UP: begin
                    // A hot die keeps the amplifiers off after a thermal shutdown.
                    if (!cmd_read_i && !(pwr_q == dcm_pkg::DCM_PWR_THERMAL_DOWN
                                         && ot_q)) begin
                        pwr_d = dcm_pkg::DCM_PWR_ON;
                    end
                end
                `DCM_CMD_SOFT_RST: begin
                    if (!cmd_read_i) begin
                        cfg_d = rst_word;
                        mon_d = `DCM_MON_OFF;
                        pwr_d = dcm_pkg::DCM_PWR_ON;
                    end
                end
                default: begin
                    cfg_d = cfg_q;
                end
            endcase
        end
        // Shutdown wins over any command in the same cycle.
        if (ot_q && fld(cfg_q, `DCM_W_THERM_EN, `DCM_N_THERM_EN)) begin
            pwr_d = dcm_pkg::DCM_PWR_THERMAL_DOWN;
        end
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= NARROW ? {2'b00, 1'b1, REF_LEVEL_RST, 10'h000}
                            : {1'b1, REF_LEVEL_RST, 12'h000};
            mon_q <= `DCM_MON_OFF;
            pwr_q <= dcm_pkg::DCM_PWR_ON;
            rb_q  <= 14'h0000;
            rbv_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            mon_q <= mon_d;
            pwr_q <= pwr_d;
            rb_q  <= rb_d;
            rbv_q <= rbv_d;
        end
    end

    assign cfg_bus.mon_enable = fld(cfg_q, `DCM_W_MON_EN, `DCM_N_MON_EN);
    assign cfg_bus.mon_code   = mon_q;
    assign cfg_bus.tgl_lo_en  = fld(cfg_q, `DCM_W_TGL_LO, `DCM_N_TGL_LO);
    assign cfg_bus.tgl_hi_en  = (NUM_CH > 8) &&
        fld(cfg_q, `DCM_W_TGL_HI, `DCM_N_TGL_HI);

    dcm_mon_route #(.NUM_CH(NUM_CH)) u_mon (
        .ref_clk_i  (ref_clk_i),
        .resetn_i   (resetn_i),
        .cfg        (cfg_bus),
        .route_o    (monitor_route_o),
        .route_ch_o (monitor_channel_o)
    );

    dcm_toggle #(.NUM_CH(NUM_CH)) u_tgl (
        .ref_clk_i         (ref_clk_i),
        .resetn_i          (resetn_i),
        .cfg               (cfg_bus),
        .load_dac_strobe_i (load_dac_strobe_i),
        .sel_b_o           (toggle_sel_b_o)
    );

    // Registered analog controls; the hardware pin ORs into power-down.
    logic pd_d;
    logic pd_q;
    logic lvl_d;
    logic lvl_q;
    logic bst_d;
    logic bst_q;
    logic src_d;
    logic src_q;
    logic on_d;
    logic on_q;

    always_comb begin
        pd_d  = fld(cfg_q, `DCM_W_PD_STATE, `DCM_N_PD_STATE);
        lvl_d = fld(cfg_q, `DCM_W_REF_LEVEL, `DCM_N_REF_LEVEL);
        bst_d = fld(cfg_q, `DCM_W_BOOST, `DCM_N_BOOST);
        src_d = fld(cfg_q, `DCM_W_REF_SRC, `DCM_N_REF_SRC);
        on_d  = (pwr_q == dcm_pkg::DCM_PWR_ON) && !hpd_q;
    end

    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pd_q  <= 1'b1;
            lvl_q <= REF_LEVEL_RST;
            bst_q <= 1'b0;
            src_q <= 1'b0;
            on_q  <= 1'b0;
        end else begin
            pd_q  <= pd_d;
            lvl_q <= lvl_d;
            bst_q <= bst_d;
            src_q <= src_d;
            on_q  <= on_d;
        end
    end

    assign pd_output_state_o = pd_q;
    assign int_ref_level_o   = lvl_q;
    assign amp_boost_o       = bst_q;
    assign ref_source_sel_o  = src_q;
    assign amps_powered_o    = on_q;
    assign readback_o        = rb_q;
    assign readback_valid_o  = rbv_q;
endmodule : dcm_ctrl

//--- sim/dcm_ctrl_assertions.sv
// Assertion checker for the control and monitor-select block.
`timescale 1ns/1ns
module dcm_ctrl_chk #(
    parameter int NUM_CH = 16
) (
    // Clock, reset, command word and over-temperature input.
    input wire logic           ref_clk_i,
    input wire logic           resetn_i,
    input wire logic           cmd_valid_i,
    input wire logic           cmd_read_i,
    input wire logic           reg_select_hi_i,
    input wire logic           reg_select_lo_i,
    input wire logic [3:0]     cmd_addr_i,
    input wire logic [13:0]    payload_i,
    input wire logic           over_temp_i,
    // Watched outputs.
    input wire logic           readback_valid_o,
    input wire logic           pd_output_state_o,
    input wire logic           int_ref_level_o,
    input wire logic           amp_boost_o,
    input wire logic           ref_source_sel_o,
    input wire logic           amps_powered_o,
    input dcm_pkg::dcm_route_t monitor_route_o,
    input wire logic [3:0]     monitor_channel_o
);
    logic        special_function_command;
    logic        wr;
    logic        msel;
    logic        srst;
    logic [13:0] cfg_q;
    logic [13:0] cfg_d;
    logic [2:0]  hot_q;
    logic [2:0]  hot_d;
    assign special_function_command  = cmd_valid_i && !reg_select_hi_i && !reg_select_lo_i;
    assign wr   = special_function_command && !cmd_read_i && cmd_addr_i == 4'hC;
    assign msel = special_function_command && !cmd_read_i && cmd_addr_i == 4'hA;
    assign srst = special_function_command && !cmd_read_i && cmd_addr_i == 4'hF;
    // A soft reset rewrites the word to its defaults like a write does.
    always_comb begin
        cfg_d = wr ? payload_i : (srst ? 14'h3000 : cfg_q);
        hot_d = !over_temp_i ? 3'h0 : (hot_q == 3'h7 ? hot_q : hot_q + 3'h1);
    end
    always_ff @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cfg_q <= 14'h3000;
            hot_q <= 3'h0;
        end else begin
            cfg_q <= cfg_d;
            hot_q <= hot_d;
        end
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    AST_CFG_BITS: assert property (
        (wr || srst) |-> ##[1:2] {pd_output_state_o, int_ref_level_o,
                        amp_boost_o,
                        ref_source_sel_o} == cfg_q[13:10])
        else $error("config outputs differ from written word");
    AST_HOLD: assert property (
        !(wr || srst) [*3] |=> $stable({pd_output_state_o, int_ref_level_o,
                              amp_boost_o, ref_source_sel_o}))
        else $error("config outputs changed without a write");
    AST_MON_CH: assert property (
        msel && cfg_q[9] && payload_i[13:8] < NUM_CH |-> ##3
        monitor_route_o == dcm_pkg::DCM_ROUTE_CHANNEL &&
        monitor_channel_o == $past(payload_i[11:8], 3))
        else $error("monitor channel not routed");
    AST_MON_EXT: assert property (
        msel && cfg_q[9] && payload_i[13:8] == 6'h24 |-> ##3
        monitor_route_o == dcm_pkg::DCM_ROUTE_EXT_A)
        else $error("external input not routed");
    AST_MON_TRI: assert property (
        msel && payload_i[13:8] == 6'h3F |-> ##3
        monitor_route_o == dcm_pkg::DCM_ROUTE_OFF)
        else $error("code 63 did not three-state the monitor");
    AST_MON_OFF: assert property (
        !cfg_q[9] [*4] |-> monitor_route_o == dcm_pkg::DCM_ROUTE_OFF)
        else $error("monitor routed while disabled");
    AST_THERM: assert property (
        cfg_q[8] [*4] ##0 hot_q == 3'h7 |-> !amps_powered_o)
        else $error("amplifiers still on while hot");
    AST_COOL: assert property (
        special_function_command && cmd_addr_i == 4'h9 && cfg_q[8] && hot_q == 3'h7
        |=> !amps_powered_o [*3])
        else $error("power-up accepted while hot");
    AST_RDBK: assert property (
        special_function_command && cmd_read_i && cmd_addr_i == 4'hC |-> ##[1:2] readback_valid_o)
        else $error("read gave no readback pulse");
    COV_MON: cover property (msel && cfg_q[9]);
    COV_HOT: cover property (cfg_q[8] && hot_q == 3'h7);
    COV_RD: cover property (readback_valid_o);
endmodule : dcm_ctrl_chk

bind dcm_ctrl dcm_ctrl_chk #(.NUM_CH(NUM_CH)) u_chk (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .cmd_valid_i(cmd_valid_i),
    .cmd_read_i(cmd_read_i), .reg_select_hi_i(reg_select_hi_i),
    .reg_select_lo_i(reg_select_lo_i), .cmd_addr_i(cmd_addr_i),
    .payload_i(payload_i), .over_temp_i(over_temp_i),
    .readback_valid_o(readback_valid_o), .amps_powered_o(amps_powered_o),
    .pd_output_state_o(pd_output_state_o), .amp_boost_o(amp_boost_o),
    .int_ref_level_o(int_ref_level_o), .ref_source_sel_o(ref_source_sel_o),
    .monitor_route_o(monitor_route_o), .monitor_channel_o(monitor_channel_o));

//--- sim/dcm_host.sv
// Host model that issues decoded command words to the control block.
`timescale 1ns/1ns
module dcm_host (
    // Clock.
    input  wire logic  ref_clk_i,
    // Command word.
    output logic       cmd_valid_o,
    output logic       cmd_read_o,
    output logic       sel_hi_o,
    output logic [3:0] addr_o,
    output logic [13:0] data_o
);
    initial begin
        {cmd_valid_o, cmd_read_o, sel_hi_o, addr_o, data_o} = '0;
    end
    task automatic send(input logic rd, input logic hi, input logic [3:0] a,
                        input logic [13:0] d);
        @(posedge ref_clk_i);
        #1;
        {cmd_valid_o, cmd_read_o, sel_hi_o} = {1'b1, rd, hi};
        {addr_o, data_o} = {a, d};
        @(posedge ref_clk_i);
        #1;
        cmd_valid_o = 1'b0;
        // An idle bus shows no stale word, so a late sample cannot pass by luck.
        addr_o = ~a;
        data_o = ~d;
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask : send
endmodule : dcm_host

//--- sim/tb_dcm_ctrl.sv
// Self-checking bench for the control and monitor-select block.
`timescale 1ns/1ns
module tb_dcm_ctrl;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic        cmd_valid, cmd_read, sel_hi, rb_valid;
    logic [3:0]  cmd_addr, mon_ch;
    logic [13:0] payload, readback;
    logic        strobe = 1'b0;
    logic        over_temp = 1'b0;
    logic        sel_lo = 1'b0;
    logic        pd, ref_lvl, boost, ref_src, amps;
    logic [15:0] sel_b;
    dcm_pkg::dcm_route_t route;
    wire  [15:0] cfg_bits = {12'h000, pd, ref_lvl, boost, ref_src};
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    int          rb_cnt = 0;

    always #20 ref_clk_i = ~ref_clk_i;

    dcm_host u_host (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid),
        .cmd_read_o(cmd_read), .sel_hi_o(sel_hi), .addr_o(cmd_addr),
        .data_o(payload));
    dcm_ctrl #(.NUM_CH(16)) u_dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .cmd_valid_i(cmd_valid), .cmd_read_i(cmd_read),
        .reg_select_hi_i(sel_hi), .reg_select_lo_i(sel_lo),
        .cmd_addr_i(cmd_addr), .payload_i(payload),
        .load_dac_strobe_i(strobe), .over_temp_i(over_temp),
        .hw_power_down_i(1'b0), .readback_o(readback),
        .readback_valid_o(rb_valid), .pd_output_state_o(pd),
        .int_ref_level_o(ref_lvl), .amp_boost_o(boost),
        .ref_source_sel_o(ref_src), .amps_powered_o(amps),
        .monitor_route_o(route), .monitor_channel_o(mon_ch),
        .toggle_sel_b_o(sel_b));

    always @(posedge ref_clk_i) if (rb_valid === 1'b1) rb_cnt++;

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic pulse;
        strobe = 1'b1;
        @(posedge ref_clk_i);
        #1;
        strobe = 1'b0;
        repeat (2) @(posedge ref_clk_i);
        #1;
    endtask : pulse

    task automatic t_reset;
        chk(cfg_bits, 16'h000C);
        chk({14'h0, route}, 16'h0000);
        chk({15'h0, amps}, 16'h0001);
    endtask : t_reset

    task automatic t_cfg;
        logic [13:0] w [3] = '{14'h3FFF, 14'h0000, 14'h2A04};
        foreach (w[i]) begin
            u_host.send(1'b0, 1'b0, 4'hC, w[i]);
            u_host.send(1'b1, 1'b0, 4'hC, 14'h0000);
            chk(cfg_bits, {12'h0, w[i][13:10]});
            chk({2'h0, readback}, {2'h0, w[i] & 14'h3F0C});
        end
        chk(16'(rb_cnt), 16'h0003);
        // A word with the upper select set is not a configuration write.
        u_host.send(1'b0, 1'b1, 4'hC, 14'h0000);
        chk(cfg_bits, 16'h000A);
        // The lower select set is not a configuration write either.
        sel_lo = 1'b1;
        u_host.send(1'b0, 1'b0, 4'hC, 14'h0000);
        sel_lo = 1'b0;
        chk(cfg_bits, 16'h000A);
    endtask : t_cfg

    task automatic t_toggle;
        pulse();
        chk(sel_b, 16'h00FF);
        pulse();
        chk(sel_b, 16'h0000);
        u_host.send(1'b0, 1'b0, 4'hC, 14'h0008);
        pulse();
        chk(sel_b, 16'hFF00);
    endtask : t_toggle

    task automatic t_mon;
        logic [5:0] code [8] = '{6'h00, 6'h03, 6'h0F, 6'h10,
                                 6'h24, 6'h25, 6'h30, 6'h3F};
        logic [1:0] er [8] = '{2'h1, 2'h1, 2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
        u_host.send(1'b0, 1'b0, 4'hA, 14'h0300);
        chk({14'h0, route}, 16'h0000);
        u_host.send(1'b0, 1'b0, 4'hC, 14'h0200);
        chk({10'h000, route, mon_ch}, 16'h0013);
        foreach (code[i]) begin
            u_host.send(1'b0, 1'b0, 4'hA, {code[i], 8'hA5});
            chk({14'h0, route}, {14'h0, er[i]});
            if (er[i] == 2'h1)
                chk({12'h0, mon_ch}, {12'h0, code[i][3:0]});
        end
        u_host.send(1'b0, 1'b0, 4'hA, 14'h0300);
        u_host.send(1'b0, 1'b0, 4'hC, 14'h0000);
        chk({14'h0, route}, 16'h0000);
    endtask : t_mon

    task automatic t_therm;
        u_host.send(1'b0, 1'b0, 4'hC, 14'h0100);
        over_temp = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk({15'h0, amps}, 16'h0000);
        u_host.send(1'b0, 1'b0, 4'h9, 14'h0000);
        chk({15'h0, amps}, 16'h0000);
        over_temp = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        u_host.send(1'b0, 1'b0, 4'h9, 14'h0000);
        chk({15'h0, amps}, 16'h0001);
        // Soft power-down and power-up on a cool die.
        u_host.send(1'b0, 1'b0, 4'h8, 14'h0000);
        chk({15'h0, amps}, 16'h0000);
        u_host.send(1'b0, 1'b0, 4'h9, 14'h0000);
        chk({15'h0, amps}, 16'h0001);
        // Soft reset brings the word back to its defaults.
        u_host.send(1'b0, 1'b0, 4'hF, 14'h0000);
        chk(cfg_bits, 16'h000C);
        chk({14'h0, route}, 16'h0000);
    endtask : t_therm

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    // The ceiling is about fifteen times the expected run so slow answers still fit.
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_of_test();
        end
    end

    initial begin
        repeat (3) @(posedge ref_clk_i);
        #1;
        resetn_i = 1'b1;
        repeat (5) @(posedge ref_clk_i);
        #1;
        t_reset();
        t_cfg();
        t_toggle();
        t_mon();
        t_therm();
        end_of_test();
    end
endmodule : tb_dcm_ctrl
